// ### adc_cal_bank.sv
// Bank of gain, offset and DAC trim registers with its access pointer.
// Assumes the host and the engine never write the same register together.
`timescale 1ns/10ps
`default_nettype none
module adc_cal_bank #(
   parameter int N_REGS = `ADC_N_CAL
) (
   // System.
   input  wire logic               clk,
   input  wire logic               resetn,
   // Pointer control.
   input  wire logic [1:0]         target,
   input  wire logic               ptr_reset,
   input  wire logic               access,
   output var  logic [3:0]         ptr,
   // Host data.
   input  wire logic               host_we,
   input  wire adc_pkg::adc_trim_t host_data,
   output var  adc_pkg::adc_trim_t rd_data,
   // Calibration engine.
   input  wire logic               eng_we,
   input  wire logic [3:0]         eng_idx,
   input  wire adc_pkg::adc_trim_t eng_data,
   output var  adc_pkg::adc_trim_t gain_trim,
   output var  adc_pkg::adc_trim_t offset_trim
);
   import adc_pkg::*;

   adc_trim_t  trim [N_REGS];
   logic [3:0] cnt;
   logic [3:0] first;
   logic       last;

   assign first       = adc_seq_start(target);
   assign last        = (cnt == adc_seq_len(target) - 4'h1);
   assign rd_data     = trim[ptr];
   assign gain_trim   = trim[`ADC_IDX_GAIN];
   assign offset_trim = trim[`ADC_IDX_OFFSET];

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ptr <= `ADC_IDX_GAIN;
         cnt <= '0;
      end else if (ptr_reset || (access && last)) begin
         ptr <= first;
         cnt <= '0;
      end else if (access) begin
         ptr <= ptr + 4'h1;
         cnt <= cnt + 4'h1;
      end
   end

   for (genvar i = 0; i < N_REGS; i++) begin : g_trim
      always_ff @(posedge clk) begin
         if (!resetn) begin
            trim[i] <= `ADC_TRIM_RESET;
         end else if (eng_we && eng_idx == 4'(i)) begin
            trim[i] <= eng_data;
         end else if (host_we && access && ptr == 4'(i)) begin
            trim[i] <= host_data;
         end
      end
   end
endmodule : adc_cal_bank
`default_nettype wire

// ### adc_defs.svh
// Constants of the converter status and trim register block.
// Assumes it is included by the package before any design file is compiled.
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH
`define ADC_WORD_W          16
`define ADC_DATA_W          14
`define ADC_N_DAC           8
`define ADC_N_CAL           (2 + `ADC_N_DAC)
`define ADC_IDX_GAIN        4'h0
`define ADC_IDX_OFFSET      4'h1
`define ADC_LEN_ALL         4'ha
`define ADC_LEN_PAIR        4'h2
`define ADC_LEN_ONE         4'h1
`define ADC_TGT_ALL         2'h0
`define ADC_TGT_PAIR        2'h1
`define ADC_TGT_OFFSET      2'h2
`define ADC_TGT_GAIN        2'h3
`define ADC_RB_CAL          2'h2
`define ADC_RB_STATUS       2'h3
`define ADC_DEST_CTRL       2'h1
`define ADC_DEST_TRIM       2'h2
`define ADC_DEST_HI         15
`define ADC_DEST_LO         14
`define ADC_CF_GO           0
`define ADC_CF_TGT_LO       1
`define ADC_CF_TGT_HI       2
`define ADC_CF_KIND         3
`define ADC_CF_CONV         4
`define ADC_CF_IFACE        5
`define ADC_CF_RB_LO        6
`define ADC_CF_RB_HI        7
`define ADC_CF_PWR_LO       8
`define ADC_CF_PWR_HI       9
`define ADC_CF_CHAN_LO      10
`define ADC_CF_CHAN_HI      12
`define ADC_CF_MODE         13
`define ADC_SF_ZERO         15
`define ADC_SF_BUSY         14
`define ADC_SF_UNDEF        4
`define ADC_SF_CALRUN       0
`define ADC_CTRL_RESET      14'h0000
`define ADC_CTRL_PULSE_MASK 14'h0011
`define ADC_STATUS_RESET    16'h0000
`define ADC_TRIM_RESET      14'h0000
`define ADC_ID_ONES         2'h3
`define ADC_LEAD_ZERO       2'h0
`define ADC_LAST_BIT        4'hf
`endif

// ### adc_host_model.sv
// Behavioural host that drives the serial register port of the trim block.
// Assumes clk is the device clock; the pins change on its falling edge.
`timescale 1ns/10ps
`default_nettype none
module adc_host_model (
   // Clock.
   input  wire logic clk,
   // Serial pins.
   output var  logic sclk_pin,
   output var  logic sync_n_pin,
   output var  logic din_pin,
   input  wire logic dout
);
   import adc_pkg::*;
   // Five clocks a phase leaves margin over the pin synchronisers.
   localparam int PH = 5;
   initial begin
      sclk_pin   = 1'b0;
      sync_n_pin = 1'b1;
      din_pin    = 1'b0;
   end
   // One whole frame, MSB first; never cut short, so two-wire reads complete.
   task automatic xfer(input adc_word_t tx, output adc_word_t rx);
      @(negedge clk);
      sync_n_pin = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         din_pin = tx[i];
         repeat (PH) @(negedge clk);
         rx[i]    = dout;
         sclk_pin = 1'b1;
         repeat (PH) @(negedge clk);
         sclk_pin = 1'b0;
      end
      repeat (2) @(negedge clk);
      sync_n_pin = 1'b1;
      // A released line shows the inverse of its last bit, not a stale copy.
      din_pin = ~tx[0];
      repeat (2*PH) @(negedge clk);
   endtask : xfer
endmodule : adc_host_model
`default_nettype wire

// ### adc_pkg.sv
// Types and sequence decoding shared by the status and trim register block.
// Assumes adc_defs.svh is on the include path.
`include "adc_defs.svh"
package adc_pkg;
   typedef logic [`ADC_WORD_W-1:0] adc_word_t;
   typedef logic [`ADC_DATA_W-1:0] adc_trim_t;
   typedef enum logic [1:0] {FR_IDLE, FR_SHIFT, FR_WAIT} adc_frame_e;

   // First register of the selected access sequence.
   function automatic logic [3:0] adc_seq_start(input logic [1:0] tgt);
      adc_seq_start = (tgt == `ADC_TGT_OFFSET) ? `ADC_IDX_OFFSET : `ADC_IDX_GAIN;
   endfunction : adc_seq_start

   // Number of registers in the selected access sequence.
   function automatic logic [3:0] adc_seq_len(input logic [1:0] tgt);
      adc_seq_len = (tgt == `ADC_TGT_ALL)  ? `ADC_LEN_ALL :
                    (tgt == `ADC_TGT_PAIR) ? `ADC_LEN_PAIR : `ADC_LEN_ONE;
   endfunction : adc_seq_len
endpackage : adc_pkg

// ### adc_serial_port.sv
// Sixteen-bit full-duplex shift port sampled from the serial pins.
// Assumes the serial clock is well below a quarter of clk.
`timescale 1ns/10ps
`default_nettype none
module adc_serial_port (
   // System.
   input  wire logic               clk,
   input  wire logic               resetn,
   // Serial pins.
   input  wire logic               sclk_pin,
   input  wire logic               sync_n_pin,
   input  wire logic               din_pin,
   output var  logic               dout,
   // Word side.
   input  wire adc_pkg::adc_word_t tx_word,
   output var  adc_pkg::adc_word_t rx_word,
   output var  logic               frame_start,
   output var  logic               frame_done
);
   import adc_pkg::*;

   logic [1:0] sclk_s;
   logic [1:0] sync_s;
   logic [1:0] din_s;
   logic       sclk_d;
   adc_frame_e state;
   adc_word_t  shreg;
   logic [3:0] bitcnt;
   logic       sclk_rise;
   logic       sync_act;
   adc_word_t  next_shreg;

   assign sclk_rise  = sclk_s[1] & ~sclk_d;
   assign sync_act   = ~sync_s[1];
   assign next_shreg = {shreg[`ADC_WORD_W-2:0], din_s[1]};

   always_ff @(posedge clk) begin
      if (!resetn) begin
         sclk_s      <= '0;
         sync_s      <= '1;
         din_s       <= '0;
         sclk_d      <= 1'b0;
         state       <= FR_IDLE;
         shreg       <= '0;
         bitcnt      <= '0;
         dout        <= 1'b0;
         rx_word     <= '0;
         frame_start <= 1'b0;
         frame_done  <= 1'b0;
      end else begin
         sclk_s      <= {sclk_s[0], sclk_pin};
         sync_s      <= {sync_s[0], sync_n_pin};
         din_s       <= {din_s[0], din_pin};
         sclk_d      <= sclk_s[1];
         frame_start <= 1'b0;
         frame_done  <= 1'b0;
         unique case (state)
            FR_IDLE: if (sync_act) begin
               state       <= FR_SHIFT;
               shreg       <= tx_word;
               dout        <= tx_word[`ADC_WORD_W-1];
               bitcnt      <= '0;
               frame_start <= 1'b1;
            end
            // A frame cut short by the host is dropped without effect.
            FR_SHIFT: if (!sync_act) begin
               state <= FR_IDLE;
            end else if (sclk_rise) begin
               shreg  <= next_shreg;
               dout   <= shreg[`ADC_WORD_W-2];
               bitcnt <= bitcnt + 4'h1;
               if (bitcnt == `ADC_LAST_BIT) begin
                  rx_word    <= next_shreg;
                  frame_done <= 1'b1;
                  state      <= FR_WAIT;
               end
            end
            FR_WAIT: if (!sync_act) begin
               state <= FR_IDLE;
            end
         endcase
      end
   end
endmodule : adc_serial_port
`default_nettype wire

// ### adc_status_and_trim_registers_tb.sv
// Self-checking bench for the status word and trim register access.
// Assumes the package and design files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module adc_status_and_trim_registers_tb;
   import adc_pkg::*;
   logic clk, resetn, sclk_pin, sync_n_pin, din_pin, dout, conv_busy, conv_start;
   logic cal_done, eng_we, cal_start, cal_active, input_mode_sel, two_wire_mode, cal_kind_sel;
   logic [3:0] eng_idx;
   logic [2:0] chan_sel;
   logic [1:0] pwr_sel, cal_target;
   adc_word_t conv_result, status_word, r;
   adc_trim_t eng_data, gain_trim, offset_trim;
   adc_trim_t exp_trim [10];
   int error_cnt, samples_checked, conv_cnt, cal_cnt;

   adc_status_trim dut (.clk, .resetn, .sclk_pin, .sync_n_pin, .din_pin, .dout, .conv_busy,
      .conv_result, .conv_start, .cal_done, .eng_we, .eng_idx, .eng_data, .cal_start,
      .cal_active, .gain_trim, .offset_trim, .input_mode_sel, .chan_sel, .pwr_sel,
      .two_wire_mode, .cal_kind_sel, .cal_target, .status_word);
   adc_host_model host (.clk, .sclk_pin, .sync_n_pin, .din_pin, .dout);

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(negedge clk) begin
      if (conv_start === 1'b1) conv_cnt++;
      if (cal_start === 1'b1) cal_cnt++;
   end

   task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task automatic stop_test;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   // Control word: mode and channel, power, readback, interface, start, kind, target, go.
   function automatic adc_word_t ctl(input logic [3:0] mch, input logic [1:0] pw, rb,
         input logic ifc, cv, kd, input logic [1:0] tg, input logic go);
      return {2'h1, mch, pw, rb, ifc, cv, kd, tg, go};
   endfunction : ctl

   function automatic int seq_idx(input logic [1:0] tg, input int k);
      return (tg == 2'h2) ? 1 : (tg == 2'h3) ? 0 : k;
   endfunction : seq_idx

   task automatic sc_reset;
      resetn = 1'b0;
      repeat (16) @(negedge clk);
      check("status in reset", 16'h0000, status_word);
      resetn = 1'b1;
      #1 check("status at release", 16'h0000, status_word);
      @(posedge clk);
      #1 check("status first edge", 16'h00c0, status_word);
      @(posedge clk);
      #1 check("status id bits", 16'h00c0, status_word);
   endtask : sc_reset

   task automatic sc_status;
      host.xfer(ctl(4'hd, 2'h2, 2'h0, 1'b1, 1'b1, 1'b1, 2'h1, 1'b0), r);
      host.xfer(16'h0000, r);
      check("conversion word", 16'h2a5c, r);
      check("start pulses", 16'h0001, conv_cnt[15:0]);
      host.xfer(ctl(4'hd, 2'h2, 2'h3, 1'b1, 1'b0, 1'b1, 2'h1, 1'b0), r);
      check("fields", 16'h2edb, {chan_sel, input_mode_sel, pwr_sel, two_wire_mode,
            cal_kind_sel, cal_target, 4'hb});
      check("status live", 16'h36ea, status_word);
      host.xfer(16'hffff, r);
      check("status read", 16'h36ea, r);
      check("status after", 16'h36ca, status_word);
      check("iface cleared", 16'h0000, {15'h0, two_wire_mode});
      @(negedge clk) conv_busy = 1'b1;
      repeat (3) @(negedge clk);
      check("busy bit", 16'h1, {15'h0, status_word[14]});
      conv_busy = 1'b0;
   endtask : sc_status

   task automatic sc_cal;
      host.xfer(ctl(4'h0, 2'h0, 2'h3, 1'b0, 1'b0, 1'b0, 2'h3, 1'b1), r);
      check("cal running", 16'h0001, {15'h0, cal_active});
      check("cal status", 16'h40c7, status_word);
      host.xfer({2'h2, 14'h3fff}, r);
      @(negedge clk) {eng_we, eng_idx, eng_data} = {1'b1, 4'h1, 14'h2bcd};
      @(negedge clk) eng_we = 1'b0;
      exp_trim[1] = 14'h2bcd;
      cal_done = 1'b1;
      @(negedge clk) cal_done = 1'b0;
      repeat (3) @(negedge clk);
      check("cal ended", 16'h00c6, status_word);
      check("engine offset", {2'h0, exp_trim[1]}, {2'h0, offset_trim});
      check("host write refused", 16'h0000, {2'h0, gain_trim});
      check("go pulses", 16'h0001, cal_cnt[15:0]);
   endtask : sc_cal

   task automatic sc_trim(input logic [1:0] tg);
      int n;
      adc_trim_t d;
      n = (tg == 2'h0) ? 10 : (tg == 2'h1) ? 2 : 1;
      host.xfer(ctl(4'h0, 2'h0, 2'h2, 1'b0, 1'b0, 1'b0, tg, 1'b0), r);
      for (int k = 0; k < n; k++) begin
         d = 14'h1000 + {tg, 8'h00} + 14'(k * 17);
         host.xfer({2'h2, d}, r);
         exp_trim[seq_idx(tg, k)] = d;
      end
      check("gain out", {2'h0, exp_trim[0]}, {2'h0, gain_trim});
      check("offset out", {2'h0, exp_trim[1]}, {2'h0, offset_trim});
      for (int k = 0; k <= n; k++) begin
         host.xfer(16'h0000, r);
         check("trim read", {2'h0, exp_trim[seq_idx(tg, k % n)]}, r);
      end
   endtask : sc_trim

   task automatic sc_abort;
      host.xfer(ctl(4'h0, 2'h0, 2'h2, 1'b0, 1'b0, 1'b0, 2'h1, 1'b0), r);
      host.xfer(16'h0000, r);
      host.xfer(ctl(4'h0, 2'h0, 2'h2, 1'b0, 1'b0, 1'b0, 2'h1, 1'b0), r);
      host.xfer(16'h0000, r);
      check("restart gain", {2'h0, exp_trim[0]}, r);
      check("no cal started", 16'h0001, cal_cnt[15:0]);
   endtask : sc_abort

   initial begin
      {resetn, conv_busy, cal_done, eng_we, eng_idx, eng_data} = '0;
      conv_result = 16'h2a5c;
      {error_cnt, samples_checked, conv_cnt, cal_cnt} = '0;
      sc_reset();
      sc_status();
      sc_cal();
      for (int t = 0; t < 4; t++) sc_trim(2'(t));
      sc_abort();
      stop_test();
   end
   initial begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      $display("mismatch run length expected end seen hang");
      stop_test();
   end
endmodule : adc_status_and_trim_registers_tb
`default_nettype wire

// ### adc_status_trim.sv
// Control, status word and trim register access of the sampling converter.
// Assumes the conversion and calibration engines run on clk.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Sixteen-bit read-only status word, returned only when readback select is both ones.
// - Every status bit is zero after reset.
// - Status bit 15 always reads zero.
// - Status bit 14 is one while conversion or calibration runs.
// - Status bits 13 to 10 mirror input mode and channel select.
// - Status bits 9 and 8 mirror the power selection bits.
// - Status bits 7 and 6 read as ones, identifying the status word.
// - Status bit 5 mirrors interface mode, cleared after every read cycle.
// - Status bit 3 mirrors calibration kind; bit 4 carries no value.
// - Status bit 0 is one while a calibration runs.
// - Status bits 2 and 1 mirror the calibration target selection.
// - Ten trim registers, eight DAC, offset and gain, all read and write.
// - Calibration updates the trim registers without host accesses.
// - Target selects all ten, gain and offset, offset only, or gain only.
// - One target governs reads and writes; host never mixes them.
// - Pointer returns to sequence start on control write or sequence end.
// - After reset pointer addresses gain, or offset when offset-only selected.
// - Pointer advances by one after each access in multi-register sequences.
// - Host may abandon a sequence; next control write resets the pointer.
// - Trim words read with two leading zeros above fourteen data bits.
// - With calibration start clear, target bits act as a trim address.
// - Readback select bits decide which word later reads return.
module adc_status_trim (
   // System.
   input  wire logic               clk,
   input  wire logic               resetn,
   // Serial pins.
   input  wire logic               sclk_pin,
   input  wire logic               sync_n_pin,
   input  wire logic               din_pin,
   output var  logic               dout,
   // Conversion engine.
   input  wire logic               conv_busy,
   input  wire adc_pkg::adc_word_t conv_result,
   output var  logic               conv_start,
   // Calibration engine.
   input  wire logic               cal_done,
   input  wire logic               eng_we,
   input  wire logic [3:0]         eng_idx,
   input  wire adc_pkg::adc_trim_t eng_data,
   output var  logic               cal_start,
   output var  logic               cal_active,
   output var  adc_pkg::adc_trim_t gain_trim,
   output var  adc_pkg::adc_trim_t offset_trim,
   // Control settings and status word.
   output var  logic               input_mode_sel,
   output var  logic [2:0]         chan_sel,
   output var  logic [1:0]         pwr_sel,
   output var  logic               two_wire_mode,
   output var  logic               cal_kind_sel,
   output var  logic [1:0]         cal_target,
   output var  adc_pkg::adc_word_t status_word
);
   import adc_pkg::*;

   logic [`ADC_DATA_W-1:0] ctrl;
   logic [`ADC_DATA_W-1:0] next_ctrl;
   logic [1:0]             frame_rb;
   logic [1:0]             readback_sel;
   logic [1:0]             rx_dest;
   logic [1:0]             bank_target;
   adc_word_t              rx_word;
   adc_word_t              tx_word;
   adc_word_t              next_status_word;
   adc_trim_t              trim_rd;
   logic [3:0]             cal_ptr;
   logic                   frame_start;
   logic                   frame_done;
   logic                   ctrl_wr;
   logic                   trim_wr;
   logic                   trim_rd_ev;
   logic                   cal_access;
   logic                   host_we;
   logic                   cal_go_wr;

   // Serial word transport.
   adc_serial_port u_port (
      .clk         (clk),
      .resetn      (resetn),
      .sclk_pin    (sclk_pin),
      .sync_n_pin  (sync_n_pin),
      .din_pin     (din_pin),
      .dout        (dout),
      .tx_word     (tx_word),
      .rx_word     (rx_word),
      .frame_start (frame_start),
      .frame_done  (frame_done)
   );

   // Trim registers and their access pointer.
   adc_cal_bank #(
      .N_REGS (`ADC_N_CAL)
   ) u_bank (
      .clk         (clk),
      .resetn      (resetn),
      .target      (bank_target),
      .ptr_reset   (ctrl_wr),
      .access      (cal_access),
      .ptr         (cal_ptr),
      .host_we     (host_we),
      .host_data   (rx_word[`ADC_DATA_W-1:0]),
      .rd_data     (trim_rd),
      .eng_we      (eng_we),
      .eng_idx     (eng_idx),
      .eng_data    (eng_data),
      .gain_trim   (gain_trim),
      .offset_trim (offset_trim)
   );

   // The two top bits of a received word say where it goes.
   assign rx_dest      = rx_word[`ADC_DEST_HI:`ADC_DEST_LO];
   // A control write restarts the pointer from the target it carries, since the old one is being replaced.
   assign bank_target  = ctrl_wr ? rx_word[`ADC_CF_TGT_HI:`ADC_CF_TGT_LO] : cal_target;
   assign ctrl_wr      = frame_done & (rx_dest == `ADC_DEST_CTRL);
   assign trim_wr      = frame_done & (rx_dest == `ADC_DEST_TRIM);
   assign trim_rd_ev   = frame_done & ~ctrl_wr & ~trim_wr & (frame_rb == `ADC_RB_CAL);
   // Host trim traffic is ignored while calibration owns the bank.
   assign cal_access   = (trim_wr | trim_rd_ev) & ~cal_active;
   assign host_we      = trim_wr & ~cal_active;
   assign cal_go_wr    = ctrl_wr & rx_word[`ADC_CF_GO];
   assign next_ctrl    = rx_word[`ADC_DATA_W-1:0] & ~`ADC_CTRL_PULSE_MASK;
   assign readback_sel = ctrl[`ADC_CF_RB_HI:`ADC_CF_RB_LO];

   // Control fields leave the block straight from the control register.
   assign input_mode_sel = ctrl[`ADC_CF_MODE];
   assign chan_sel       = ctrl[`ADC_CF_CHAN_HI:`ADC_CF_CHAN_LO];
   assign pwr_sel        = ctrl[`ADC_CF_PWR_HI:`ADC_CF_PWR_LO];
   assign two_wire_mode  = ctrl[`ADC_CF_IFACE];
   assign cal_kind_sel   = ctrl[`ADC_CF_KIND];
   assign cal_target     = ctrl[`ADC_CF_TGT_HI:`ADC_CF_TGT_LO];

   assign next_status_word = {1'b0,
                              conv_busy | cal_active,
                              ctrl[`ADC_CF_MODE:`ADC_CF_PWR_LO],
                              `ADC_ID_ONES,
                              ctrl[`ADC_CF_IFACE],
                              1'b0,
                              ctrl[`ADC_CF_KIND:`ADC_CF_TGT_LO],
                              cal_active};

   // The word returned is the one selected when the frame opens.
   assign tx_word = (readback_sel == `ADC_RB_STATUS) ? status_word :
                    (readback_sel == `ADC_RB_CAL)    ? {`ADC_LEAD_ZERO, trim_rd}
                                                     : conv_result;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl <= `ADC_CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl <= next_ctrl;
      end else if (frame_done) begin
         ctrl[`ADC_CF_IFACE] <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         status_word <= `ADC_STATUS_RESET;
      end else begin
         status_word <= next_status_word;
      end
   end

   // A start request in the same cycle as a done report wins.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cal_active <= 1'b0;
      end else if (cal_go_wr) begin
         cal_active <= 1'b1;
      end else if (cal_done) begin
         cal_active <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         conv_start <= 1'b0;
         cal_start  <= 1'b0;
         frame_rb   <= '0;
      end else begin
         conv_start <= ctrl_wr & rx_word[`ADC_CF_CONV];
         cal_start  <= cal_go_wr;
         if (frame_start) begin
            frame_rb <= readback_sel;
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_ctrl_write;
      ctrl_wr;
   endsequence

   sequence s_go_write;
      cal_go_wr;
   endsequence

   sequence s_pair_gain_access;
      cal_access && !ctrl_wr && cal_target == `ADC_TGT_PAIR && cal_ptr == `ADC_IDX_GAIN;
   endsequence

   chk_status_reset: assert property (@(posedge clk) disable iff (1'b0)
      !resetn |=> status_word == `ADC_STATUS_RESET)
      else $error("status word not cleared by reset");

   chk_status_top_zero: assert property (status_word[`ADC_SF_ZERO] == 1'b0)
      else $error("status bit 15 not zero");

   chk_status_busy: assert property ($past(resetn) |->
      status_word[`ADC_SF_BUSY] == ($past(conv_busy) | $past(cal_active)))
      else $error("busy bit does not follow activity");

   chk_status_mirror: assert property ($past(resetn) |->
      status_word[`ADC_CF_MODE:`ADC_CF_PWR_LO] == $past(ctrl[`ADC_CF_MODE:`ADC_CF_PWR_LO]))
      else $error("status does not mirror mode channel power");

   chk_status_ident: assert property ($past(resetn) |->
      status_word[`ADC_CF_RB_HI:`ADC_CF_RB_LO] == `ADC_ID_ONES)
      else $error("status identity bits not ones");

   chk_iface_clear: assert property (frame_done && !ctrl_wr |=> ##1
      !status_word[`ADC_CF_IFACE])
      else $error("interface mode bit not cleared after read");

   chk_status_target: assert property ($past(resetn) |->
      status_word[`ADC_CF_TGT_HI:`ADC_CF_TGT_LO] == $past(cal_target) &&
      status_word[`ADC_SF_UNDEF] == 1'b0)
      else $error("status target bits wrong");

   chk_cal_run_flag: assert property (s_go_write |=> cal_active ##1
      status_word[`ADC_SF_CALRUN])
      else $error("calibration run flag not raised");

   chk_cal_start_pulse: assert property (s_go_write |=> cal_start ##1 !cal_start)
      else $error("calibration start not a single pulse");

   chk_status_select: assert property (readback_sel == `ADC_RB_STATUS |->
      tx_word == status_word)
      else $error("status word not offered for readback");

   chk_trim_zeros: assert property (readback_sel == `ADC_RB_CAL |->
      tx_word[`ADC_DEST_HI:`ADC_DEST_LO] == `ADC_LEAD_ZERO && tx_word[`ADC_DATA_W-1:0] == trim_rd)
      else $error("trim readback lacks leading zeros");

   chk_ptr_reset: assert property (s_ctrl_write |=>
      cal_ptr == adc_seq_start(cal_target))
      else $error("pointer not at sequence start after control write");

   chk_ptr_advance: assert property (s_pair_gain_access |=>
      cal_ptr == `ADC_IDX_OFFSET)
      else $error("pointer did not advance in pair sequence");

   chk_ptr_single: assert property (cal_access && !ctrl_wr && cal_target == `ADC_TGT_OFFSET |=>
      cal_ptr == `ADC_IDX_OFFSET)
      else $error("offset-only pointer moved off offset");

   chk_ptr_idle: assert property (!cal_access && !ctrl_wr |=> $stable(cal_ptr))
      else $error("pointer moved without an access");

   chk_ptr_after_reset: assert property (@(posedge clk) disable iff (1'b0)
      !resetn |=> cal_ptr == `ADC_IDX_GAIN)
      else $error("pointer not at gain after reset");

   chk_busy_trim_block: assert property (trim_wr && cal_active |-> !host_we && !cal_access)
      else $error("host trim write accepted during calibration");
endmodule : adc_status_trim
`default_nettype wire
